// File: include/sld_defs.svh
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// Display RAM shape
`define SLD_ADDR_W      5
`define SLD_RAM_WORDS   32
`define SLD_WORD_W      4
`define SLD_COM_N       4
`define SLD_SEG_N       32

// Address counter values
`define SLD_ADDR_RST    5'h00
`define SLD_ADDR_LAST   5'h1f

// Command opcodes in the top three bits of a command byte
`define SLD_OP_ADDR     3'h0
`define SLD_OP_DON      3'h1
`define SLD_OP_DOFF     3'h2
`define SLD_OP_START    3'h3
`define SLD_OP_REWRITE  3'h4
`define SLD_OP_RESET    3'h7

// Byte layout on the link
`define SLD_OP_MSB      7
`define SLD_OP_LSB      5
`define SLD_BITS_LAST   3'h7

// Buffering and scan timing
`define SLD_FIFO_DEPTH  8
`define SLD_XFER_W      9
`define SLD_SCAN_DIV    4'hf

`endif

// File: include/sld_pkg.sv
package sld_pkg;

  // One byte taken from the link, with its command/data flag
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] val;
  } sld_xfer_type;

  // Executor states, one-hot
  typedef enum logic [1:0] {
    SLD_ST_IDLE   = 2'b01,
    SLD_ST_SECOND = 2'b10
  } sld_state_type;

endpackage

// File: logic/sld_ctrl.sv
`timescale 1ns/1ps
`include "sld_defs.svh"
// Summary of operation
// - Select low marks display data, select high marks a command byte.
// - Serial clock and data count only while chip select is low.
// - Reset low clears the address counter and turns the display off.
// - Address-set command loads its address into the address counter.
// - Data byte writes two RAM words, address counter advances by two.
// - Four-bit rewrite inside a command byte writes one word, plus one.
// - After address 1fh the next increment wraps to 00h.
// - Display RAM holds 32 words of four bits.
// - Timing from resistor oscillator or external clock; output pin open in external mode.
// - Select level is taken at the eighth rising serial clock edge.
// - Address-set has top bits 000, five address bits, loaded at byte end.
// - Display-on (001) shows RAM contents and leaves RAM unchanged.
// - Opcode 100 writes low nibble at the address, then adds one.
// - Reset command blanks the display and clears the address counter.
module sld_ctrl (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  sck_in,
  input  wire logic                  serial_din_in,
  input  wire logic                  cmd_sel_in,
  input  wire logic                  cs_n_in,
  input  wire logic                  ext_clk_mode_in,
  input  wire logic                  osc_in_pin_in,
  output logic                       osc_out_pin_out,
  output logic                       osc_out_pin_oe_out,
  output logic [`SLD_COM_N-1:0]      common_outputs_out,
  output logic [`SLD_SEG_N-1:0]      segment_outputs_out,
  output sld_pkg::sld_xfer_type      last_xfer_out
);
  import sld_pkg::*;

  logic [2:0]                bit_cnt_q;
  logic [7:0]                shift_q;
  sld_xfer_type              hold_q;
  logic                      tog_q;
  logic                      tog_s1_q;
  logic                      tog_s2_q;
  logic                      tog_s3_q;
  logic                      pend_q;
  sld_xfer_type              pend_data_q;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  logic [`SLD_XFER_W-1:0]    fifo_out_bits;
  sld_xfer_type              item;
  logic                      pop;
  logic [2:0]                opcode;
  sld_state_type             state_q;
  logic [`SLD_ADDR_W-1:0]    addr_q;
  logic [`SLD_WORD_W-1:0]    low_nib_q;
  logic                      disp_on_q;
  logic                      osc_run_q;
  logic [`SLD_WORD_W-1:0]    ram_q [`SLD_RAM_WORDS];
  logic                      osc_s1_q;
  logic                      osc_s2_q;
  logic                      osc_s3_q;
  logic                      mode_s1_q;
  logic                      mode_s2_q;
  logic [3:0]                div_q;
  logic [1:0]                com_idx_q;

  // bit counter restarts at chip select fall
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      bit_cnt_q <= 3'h0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // MSB-first shift on rising serial clock
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      shift_q <= 8'h00;
    end
    else
    begin
      shift_q <= {shift_q[6:0], serial_din_in};
    end
  end

  // byte classified by select level
  // Held word stays put for a whole byte time, far longer than the sync
  always_ff @(posedge sck_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hold_q <= '0;
      tog_q  <= 1'b0;
    end
    else if (bit_cnt_q == `SLD_BITS_LAST)
    begin
      hold_q <= '{is_cmd: cmd_sel_in, val: {shift_q[6:0], serial_din_in}};
      tog_q  <= ~tog_q;
    end
  end

  // Toggle crossing into the system clock
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else
    begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Pending slot waits while the FIFO is full; a byte arriving then overwrites the waiting one
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end
    else if (tog_s2_q ^ tog_s3_q)
    begin
      pend_q      <= 1'b1;
      pend_data_q <= hold_q;
    end
    else if (fifo_in_ready)
    begin
      pend_q <= 1'b0;
    end
  end

  sld_fifo #(
    .WIDTH (`SLD_XFER_W),
    .DEPTH (`SLD_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (pend_q),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_data_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_bits)
  );

  // Executor takes a byte only when idle; data bytes stall one cycle
  assign item           = fifo_out_bits;
  assign fifo_out_ready = (state_q == SLD_ST_IDLE);
  assign pop            = fifo_out_valid && fifo_out_ready;
  assign opcode         = item.val[`SLD_OP_MSB:`SLD_OP_LSB];

  // Executor state
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= SLD_ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        SLD_ST_IDLE:
        begin
          if (pop && !item.is_cmd)
          begin
            state_q <= SLD_ST_SECOND;
          end
        end
        SLD_ST_SECOND:
        begin
          state_q <= SLD_ST_IDLE;
        end
        default:
        begin
          state_q <= SLD_ST_IDLE;
        end
      endcase
    end
  end

  // Second nibble of a data byte
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      low_nib_q <= 4'h0;
    end
    else if (pop && !item.is_cmd)
    begin
      low_nib_q <= item.val[3:0];
    end
  end

  // Address counter; five bits wrap on their own
  // reset pin clears counter
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      addr_q <= `SLD_ADDR_RST;
    end
    else if (state_q == SLD_ST_SECOND)
    begin
      addr_q <= addr_q + 5'h01;
    end
    else if (pop)
    begin
      if (!item.is_cmd)
      begin
        addr_q <= addr_q + 5'h01;
      end
      else if (opcode == `SLD_OP_ADDR)
      begin
        addr_q <= item.val[`SLD_ADDR_W-1:0];
      end
      else if (opcode == `SLD_OP_REWRITE)
      begin
        addr_q <= addr_q + 5'h01;
      end
      else if (opcode == `SLD_OP_RESET)
      begin
        addr_q <= `SLD_ADDR_RST;
      end
    end
  end

  // display RAM, 32 by 4
  // Only data bytes and rewrite touch it, so on/off/start leave it intact
  always_ff @(posedge ref_clk_in)
  begin
    if (state_q == SLD_ST_SECOND)
    begin
      ram_q[addr_q] <= low_nib_q;
    end
    else if (pop && !item.is_cmd)
    begin
      ram_q[addr_q] <= item.val[7:4];
    end
    else if (pop && opcode == `SLD_OP_REWRITE)
    begin
      ram_q[addr_q] <= item.val[3:0];
    end
  end

  // Display and oscillator control
  // reset pin blanks display
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      disp_on_q <= 1'b0;
      osc_run_q <= 1'b0;
    end
    else if (pop && item.is_cmd)
    begin
      unique case (opcode)
        `SLD_OP_DON:
        begin
          disp_on_q <= 1'b1;
        end
        `SLD_OP_DOFF:
        begin
          disp_on_q <= 1'b0;
        end
        `SLD_OP_START:
        begin
          disp_on_q <= 1'b1;
          osc_run_q <= 1'b1;
        end
        `SLD_OP_RESET:
        begin
          disp_on_q <= 1'b0;
        end
        default:
        begin
          disp_on_q <= disp_on_q;
        end
      endcase
    end
  end

  // Last byte seen, for observation
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      last_xfer_out <= '0;
    end
    else if (pop)
    begin
      last_xfer_out <= item;
    end
  end

  // Oscillator pin and mode strap pass two flops before use
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end
    else
    begin
      osc_s1_q  <= osc_in_pin_in;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      mode_s1_q <= ext_clk_mode_in;
      mode_s2_q <= mode_s1_q;
    end
  end

  // inverter drive in resistor mode, pin left open in external mode
  // Only a digital stand-in: the real loop is analog
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      osc_out_pin_out    <= 1'b0;
      osc_out_pin_oe_out <= 1'b0;
    end
    else
    begin
      osc_out_pin_out    <= ~osc_s2_q & osc_run_q;
      osc_out_pin_oe_out <= ~mode_s2_q;
    end
  end

  // Common scan: divides oscillator edges, steps one common per wrap
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      div_q     <= 4'h0;
      com_idx_q <= 2'h0;
    end
    else if (osc_run_q && osc_s2_q && !osc_s3_q)
    begin
      div_q <= div_q + 4'h1;
      if (div_q == `SLD_SCAN_DIV)
      begin
        com_idx_q <= com_idx_q + 2'h1;
      end
    end
  end

  // Panel drive; word s feeds segment s, bit c belongs to common c
  // blank when off
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in || !disp_on_q)
    begin
      common_outputs_out  <= 4'h0;
      segment_outputs_out <= 32'h0000_0000;
    end
    else
    begin
      common_outputs_out <= 4'h1 << com_idx_q;
      for (int s = 0; s < `SLD_SEG_N; s++)
      begin
        segment_outputs_out[s] <= ram_q[s][com_idx_q];
      end
    end
  end

  sequence data_pop_s;
    pop && !item.is_cmd;
  endsequence

  sequence cmd_pop_s(logic [2:0] op);
    pop && item.is_cmd && opcode == op;
  endsequence

  addr_load_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_ADDR) |=> addr_q == $past(item.val[4:0]))
    else $error("address set not loaded");

  data_two_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    data_pop_s |=> ##1 addr_q == $past(addr_q, 2) + 5'h02)
    else $error("data byte did not add two");

  rewrite_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_REWRITE) |=> addr_q == $past(addr_q) + 5'h01
      && ram_q[$past(addr_q)] == $past(item.val[3:0]))
    else $error("rewrite wrong");

  addr_wrap_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    (addr_q == `SLD_ADDR_LAST) and cmd_pop_s(`SLD_OP_REWRITE)
      |=> addr_q == `SLD_ADDR_RST)
    else $error("address did not wrap");

  pin_reset_a: assert property (@(posedge ref_clk_in)
    !rstn_in |=> addr_q == `SLD_ADDR_RST && !disp_on_q)
    else $error("reset pin did not clear");

  disp_on_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_DON) |=> disp_on_q && addr_q == $past(addr_q))
    else $error("display on failed");

  disp_blank_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_DOFF) |=> !disp_on_q ##1
      segment_outputs_out == 32'h0000_0000 && common_outputs_out == 4'h0)
    else $error("display off did not blank");

  disp_start_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_START) |=> disp_on_q && osc_run_q)
    else $error("display start failed");

  cmd_reset_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    cmd_pop_s(`SLD_OP_RESET) |=> !disp_on_q && addr_q == `SLD_ADDR_RST)
    else $error("reset command failed");

  ext_open_a: assert property (@(posedge ref_clk_in)
    disable iff (!rstn_in)
    mode_s2_q |=> !osc_out_pin_oe_out)
    else $error("oscillator output driven in external mode");
endmodule // sld_ctrl

// File: logic/sld_fifo.sv
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready_out  = !((wr_q[AW] != rd_q[AW]) &&
                           (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_out = (wr_q != rd_q);
  assign out_data_out  = mem_q[rd_q[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Storage words
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // sld_fifo

// File: tb/sld_ctrl_tb.sv
`timescale 1ns/1ps
module sld_ctrl_tb;
  import sld_pkg::*;
  logic         ref_clk_in = 1'b0;
  logic         rstn_in = 1'b0;
  logic         ext_clk_mode_in = 1'b0;
  logic         osc_in_pin_in = 1'b0;
  logic [1:0]   osc_div = 2'h0;
  logic         sck, din, sel, cs_n, osc_out, osc_oe;
  logic [3:0]   commons;
  logic [31:0]  segs;
  sld_xfer_type last_xfer, seen_q, last_exp;
  sld_xfer_type exp_q[$];
  logic [3:0]   ram_m [32];
  logic [4:0]   addr_m = 5'h00;
  int           miscompares = 0;
  int           checks = 0;

  // System clock and a slow oscillator pin (rise every 8 cycles)
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3)
      osc_in_pin_in <= ~osc_in_pin_in;
  end

  sld_ctrl u_sld_ctrl (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sck_in(sck),
    .serial_din_in(din), .cmd_sel_in(sel), .cs_n_in(cs_n),
    .ext_clk_mode_in(ext_clk_mode_in), .osc_in_pin_in(osc_in_pin_in),
    .osc_out_pin_out(osc_out), .osc_out_pin_oe_out(osc_oe),
    .common_outputs_out(commons), .segment_outputs_out(segs),
    .last_xfer_out(last_xfer));
  sld_host_model u_sld_host_model (.sck_out(sck), .din_out(din),
    .sel_out(sel), .cs_n_out(cs_n));

  task automatic chk_xfer(input sld_xfer_type e, input sld_xfer_type g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] last_xfer exp %h got %h", e, g);
    end
  endtask

  task automatic chk_bits(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  // Watcher: each change of the executed byte consumes the oldest note
  always @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      seen_q <= '0;
    else if (last_xfer !== seen_q)
    begin
      seen_q <= last_xfer;
      if (exp_q.size() == 0)
        chk_xfer('1, last_xfer);
      else
        chk_xfer(exp_q.pop_front(), last_xfer);
    end
  end

  // Send a byte, updating the RAM model; repeats give no visible change
  task automatic send(input logic c, input logic [7:0] v);
    sld_xfer_type x;
    x = {c, v};
    if (!c)
    begin
      ram_m[addr_m] = v[7:4];
      ram_m[addr_m + 5'h01] = v[3:0];
      addr_m += 5'h02;
    end
    else if (v[7:5] == 3'h0)
      addr_m = v[4:0];
    else if (v[7:5] == 3'h4)
    begin
      ram_m[addr_m] = v[3:0];
      addr_m += 5'h01;
    end
    else if (v[7:5] == 3'h7)
      addr_m = 5'h00;
    if (x !== last_exp)
      exp_q.push_back(x);
    last_exp = x;
    u_sld_host_model.shift(c, v, 8, 1'b0, 8 + $urandom_range(30));
  endtask

  task automatic settle();
    for (int i = 0; i < 400 && exp_q.size() != 0; i++)
      @(posedge ref_clk_in);
    repeat (10) @(posedge ref_clk_in);
  endtask

  // Segments must equal RAM column of the single active common
  task automatic chk_disp(input logic on);
    logic [31:0] e;
    int c;
    @(negedge ref_clk_in);
    c = 0;
    for (int k = 0; k < 4; k++)
      if (commons[k] === 1'b1)
        c = k;
    for (int s = 0; s < 32; s++)
      e[s] = on & ram_m[s][c];
    chk_bits("commons", on ? 32'(4'h1 << c) : 32'h0, 32'(commons));
    chk_bits("segments", e, segs);
  endtask

  task automatic finish_test();
    miscompares += exp_q.size();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well above the expected run length
  initial
  begin
    repeat (90000) @(posedge ref_clk_in);
    miscompares++;
    finish_test();
  end

  initial
  begin
    logic [3:0] cm;
    logic       p;
    void'($urandom(11360));
    last_exp = '0;
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk_disp(1'b0);
    chk_bits("osc_out", 32'h0, 32'(osc_out));
    // Reset command goes first after power-up
    send(1'b1, 8'he0);
    // Move the counter, then the reset command must bring it back to 0
    send(1'b1, 8'h05);
    send(1'b1, 8'h8a);
    send(1'b1, 8'he0);
    for (int i = 0; i < 17; i++)
      send(1'b0, 8'($urandom));
    send(1'b1, 8'h20);
    settle();
    chk_disp(1'b1);
    // Single-word rewrites across the top address
    send(1'b1, 8'h1f);
    send(1'b1, 8'h83);
    send(1'b1, 8'h8c);
    send(1'b1, 8'h60);
    settle();
    chk_bits("osc_oe", 32'h1, 32'(osc_oe));
    // Oscillator output is the inverted pin, three flops late
    @(negedge ref_clk_in);
    p = osc_in_pin_in;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bits("osc_out", {31'h0, ~p}, 32'(osc_out));
    for (int n = 0; n < 4; n++)
    begin
      cm = commons;
      for (int i = 0; i < 300 && commons === cm; i++)
        @(posedge ref_clk_in);
      chk_bits("step", 32'h1, 32'(commons !== cm));
      chk_disp(1'b1);
    end
    send(1'b1, 8'h40);
    settle();
    chk_disp(1'b0);
    // Deselected clocks and a partial byte must leave no trace
    u_sld_host_model.shift(1'b1, 8'h1f, 8, 1'b1, 8);
    u_sld_host_model.shift(1'b1, 8'h00, 5, 1'b0, 8);
    // Opcode 101 is a no-op: RAM and counter must stay put
    send(1'b1, 8'ha5);
    send(1'b1, 8'h85);
    send(1'b1, 8'h20);
    settle();
    chk_disp(1'b1);
    @(posedge ref_clk_in);
    ext_clk_mode_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    chk_bits("osc_oe", 32'h0, 32'(osc_oe));
    ext_clk_mode_in <= 1'b0;
    // Pin reset mid-run: display off, counter back at 0
    rstn_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    addr_m = 5'h00;
    last_exp = '0;
    chk_bits("pending", 32'h0, 32'(exp_q.size()));
    exp_q.delete();
    repeat (4) @(posedge ref_clk_in);
    chk_disp(1'b0);
    for (int i = 0; i < 32; i++)
      send(1'b1, 8'h80 | 8'($urandom_range(15)));
    send(1'b1, 8'h20);
    settle();
    chk_disp(1'b1);
    finish_test();
  end
endmodule // sld_ctrl_tb

// File: tb/sld_host_model.sv
`timescale 1ns/1ps
module sld_host_model (
  output logic sck_out,
  output logic din_out,
  output logic sel_out,
  output logic cs_n_out
);
  // Idle link: clock stands low, select off
  initial
  begin
    sck_out = 1'b0;
    din_out = 1'b0;
    sel_out = 1'b0;
    cs_n_out = 1'b1;
  end

  // Shift nbits of val; cs_hi leaves the device deselected (noise only)
  task automatic shift(input logic is_cmd, input logic [7:0] val,
                       input int nbits, input logic cs_hi, input int gap);
    cs_n_out = cs_hi;
    #62.5;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      din_out = val[i];
      sel_out = is_cmd;
      #62.5 sck_out = 1'b1;
      #62.5 sck_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    // Released lines show the inverse so stale values never match
    din_out = ~din_out;
    sel_out = ~sel_out;
    #(125.0 * gap);
  endtask
endmodule // sld_host_model
